// ==== tsa_defines.svh ====
`ifndef TSA_DEFINES_SVH
`define TSA_DEFINES_SVH

// command byte layout
`define TSA_START_BIT     7
`define TSA_CH_HI         6
`define TSA_CH_LO         4
`define TSA_MODE_BIT      3
`define TSA_REFSEL_BIT    2
`define TSA_REFPWR_BIT    1
`define TSA_CONVPWR_BIT   0

// link sequencing counts
`define TSA_ACQ_AT        4'd3
`define TSA_LAST_AT       4'd7
`define TSA_SPACING_12    5'd15
`define TSA_SPACING_8     5'd11
`define TSA_BITS_12       5'd12
`define TSA_BITS_8        5'd8
`define TSA_FRAME_CLKS    5'd24
`define TSA_RX_FROM       5'd8
`define TSA_SINCE_MAX     5'h1f
`define TSA_TOUCH_CH_MASK 8'h3a

// synchroniser reset levels
`define TSA_DEV_SYNC_RST  4'ha
`define TSA_HST_SYNC_RST  3'h4

// timing
`define TSA_PCLK_NS       8
`define TSA_SCK_HALF_NS   96
`define TSA_SCK_HALF_CYC  ((`TSA_SCK_HALF_NS + `TSA_PCLK_NS - 1) / `TSA_PCLK_NS)

// host register map
`define TSA_REG_CTRL      12'h000
`define TSA_REG_CMD       12'h004
`define TSA_REG_STATUS    12'h008
`define TSA_REG_RESULT    12'h00c
`define TSA_CTRL_CSHOLD   0
`define TSA_CTRL_ALERTEN  1
`define TSA_CTRL_RST      2'h2
`define TSA_STAT_ACTIVE   0
`define TSA_STAT_DONE     1
`define TSA_STAT_ALERT    2
`define TSA_STAT_BUSYPIN  3

`endif

// ==== tsa_pkg.sv ====
`include "tsa_defines.svh"

package tsa_pkg;

    typedef enum logic {
        RX_IDLE,
        RX_SHIFT
    } tsa_rx_e;

    typedef enum logic [1:0] {
        H_IDLE,
        H_LOW,
        H_HIGH
    } tsa_host_e;

    function automatic logic tsa_is_touch(input logic [2:0] code);
        logic [7:0] mask;
        mask = `TSA_TOUCH_CH_MASK;
        return mask[code];
    endfunction : tsa_is_touch

endpackage : tsa_pkg

// ==== tsa_link_if.sv ====
`timescale 1ns/1ps

interface tsa_link_if;
    logic serial_clock;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic busy;
    logic busy_oe;
    logic touch_alert_n;

    modport dev (
        input  serial_clock,
        input  cs_n,
        input  sdi,
        output sdo,
        output sdo_oe,
        output busy,
        output busy_oe,
        output touch_alert_n
    );

    modport host (
        output serial_clock,
        output cs_n,
        output sdi,
        input  sdo,
        input  sdo_oe,
        input  busy,
        input  busy_oe,
        input  touch_alert_n
    );
endinterface : tsa_link_if

// ==== tsa_dev.sv ====
`timescale 1ns/1ps
`include "tsa_defines.svh"

// Behaviour
// RL1: ignore input until first high bit starts
// RL2: bits 6-4 with select set mux, drivers
// RL3: bit 3 picks 12 or 8 result bits
// RL4: new start every 15th or 11th clock
// RL5: bit 2 picks single-ended or ratiometric reference
// RL6: host uses ratiometric only for touch channels
// RL7: both zero: power down between conversions
// RL8: converter on, reference off, alert disabled
// RL9: reference on, converter off, alert enabled
// RL10: both one: always powered, alert disabled
// RL11: reference power latched as busy rises
// RL12: host sends extra byte to drop reference; host sends none, only one 24-clock frame per command write
// RL13: host lets reference settle; converter instant; host starts each frame at once, with no settling wait
// RL14: powered down: ground Y, alert follows X+
// RL15: touch measurements: pull-up off, alert low
// RL16: other measurements: alert held high
// RL17: converter bit one keeps touch detect off
// RL18: converter bit zero: alert back at end
// RL19: host masks alert while sending commands
// RL20: conversion frame of three 8-clock transfers
// RL21: result follows command, msb first
// RL22: chip select high aborts, keeps reference
// RL23: classify channel as touch or auxiliary
// RL24: decoded fields held until next command
module tsa_dev
    import tsa_pkg::*;
(
    input  logic        pclk,
    input  logic        presetn,
    tsa_link_if.dev     link,
    input  logic [11:0] conv_data,
    input  logic        touch_sense_n,
    output logic [2:0]  channel_code,
    output logic        reference_select,
    output logic        resolution_8bit,
    output logic        reference_power_bit,
    output logic        converter_power_bit,
    output logic        acquire,
    output logic        touch_drive_on,
    output logic        reference_on,
    output logic        converter_on,
    output logic        y_ground_on,
    output logic        xplus_pullup_on
);

    localparam logic [3:0] SYNC_RST = `TSA_DEV_SYNC_RST;

    logic [3:0]  pin_raw;
    logic [3:0]  sync1_r;
    logic [3:0]  sync2_r;
    logic [3:0]  sync3_r;
    logic [3:0]  pin_r;
    logic [3:0]  agree;
    logic        sck_d_r;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_hi;
    logic        sdi_s;
    logic        touch_s;
    tsa_rx_e     rx_st;
    logic [7:0]  shreg_r;
    logic [7:0]  shift_nxt;
    logic [3:0]  bitcnt_r;
    logic [4:0]  since_r;
    logic        acq_touch_r;
    logic        start_take;
    logic        acq_start;
    logic        cmd_done;
    logic        conv_active_r;
    logic        conv_meas_r;
    logic [4:0]  ocnt_r;
    logic [4:0]  ocnt_nxt;
    logic        conv_mode_r;
    logic        conv_touch_r;
    logic        conv_diff_r;
    logic        conv_pd0_r;
    logic        conv_pd1_r;
    logic [11:0] data_r;
    logic [4:0]  spacing;
    logic [4:0]  nbits;
    logic        eoc_ev;
    logic        pen_en_r;
    logic        measuring;
    logic        meas_touch;

    // pins pass three flops; a level counts once flops two and three agree
    assign pin_raw = {touch_sense_n, link.sdi, link.cs_n, link.serial_clock};
    assign agree   = ~(sync2_r ^ sync3_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            sync3_r <= SYNC_RST;
            pin_r   <= SYNC_RST;
            sck_d_r <= 1'b0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_r   <= (agree & sync3_r) | (~agree & pin_r);
            sck_d_r <= pin_r[0];
        end
    end

    assign cs_hi    = pin_r[1];
    assign sdi_s    = pin_r[2];
    assign touch_s  = pin_r[3];
    assign sck_rise = pin_r[0] & ~sck_d_r & ~cs_hi;
    assign sck_fall = ~pin_r[0] & sck_d_r & ~cs_hi;

    assign spacing   = conv_mode_r ? `TSA_SPACING_8 : `TSA_SPACING_12;
    assign nbits     = conv_mode_r ? `TSA_BITS_8 : `TSA_BITS_12;
    assign shift_nxt = {shreg_r[6:0], sdi_s};
    assign ocnt_nxt  = ocnt_r + 5'd1;

    // start bit only when idle and, during a conversion, past the overlap spacing
    assign start_take = sck_rise & (rx_st == RX_IDLE) & sdi_s &
                        (~conv_active_r | (since_r >= spacing)); // [RL1] [RL4]
    assign acq_start  = sck_rise & (rx_st == RX_SHIFT) & (bitcnt_r == `TSA_ACQ_AT);
    assign cmd_done   = sck_rise & (rx_st == RX_SHIFT) & (bitcnt_r == `TSA_LAST_AT);
    assign eoc_ev     = sck_fall & conv_active_r & (ocnt_nxt == (nbits + 5'd1)); // [RL18]

    // command receiver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st       <= RX_IDLE;
            shreg_r     <= 8'h00;
            bitcnt_r    <= 4'h0;
            acquire     <= 1'b0;
            acq_touch_r <= 1'b0;
        end else if (cs_hi) begin
            rx_st    <= RX_IDLE; // [RL22]
            bitcnt_r <= 4'h0;
            acquire  <= 1'b0;
        end else if (sck_rise) begin
            unique case (rx_st)
                RX_IDLE: begin
                    if (start_take) begin
                        rx_st    <= RX_SHIFT; // [RL1]
                        shreg_r  <= 8'h01;
                        bitcnt_r <= 4'h1;
                    end
                end
                RX_SHIFT: begin
                    shreg_r  <= shift_nxt;
                    bitcnt_r <= bitcnt_r + 4'h1;
                    if (acq_start) begin
                        acquire     <= 1'b1; // [RL20]
                        acq_touch_r <= tsa_is_touch(shift_nxt[2:0]); // [RL23]
                    end
                    if (cmd_done) begin
                        rx_st   <= RX_IDLE;
                        acquire <= 1'b0;
                    end
                end
            endcase
        end
    end

    // rising edges since the last start bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_r <= 5'h00;
        end else if (start_take) begin
            since_r <= 5'h01; // [RL4]
        end else if (sck_rise && since_r != `TSA_SINCE_MAX) begin
            since_r <= since_r + 5'h01;
        end
    end

    // decoded fields, held until the next command completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_code        <= 3'h0;
            reference_select    <= 1'b0;
            resolution_8bit     <= 1'b0;
            reference_power_bit <= 1'b0;
            converter_power_bit <= 1'b0;
        end else if (cmd_done) begin
            channel_code        <= shift_nxt[`TSA_CH_HI:`TSA_CH_LO]; // [RL2] [RL24]
            reference_select    <= shift_nxt[`TSA_REFSEL_BIT]; // [RL5]
            resolution_8bit     <= shift_nxt[`TSA_MODE_BIT]; // [RL3]
            reference_power_bit <= shift_nxt[`TSA_REFPWR_BIT];
            converter_power_bit <= shift_nxt[`TSA_CONVPWR_BIT];
        end
    end

    // conversion: busy, result shift-out, reference latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_active_r <= 1'b0;
            conv_meas_r   <= 1'b0;
            ocnt_r        <= 5'h00;
            conv_mode_r   <= 1'b0;
            conv_touch_r  <= 1'b0;
            conv_diff_r   <= 1'b0;
            conv_pd0_r    <= 1'b0;
            conv_pd1_r    <= 1'b0;
            data_r        <= 12'h000;
            reference_on  <= 1'b0;
            link.busy     <= 1'b0;
            link.sdo      <= 1'b0;
            link.busy_oe  <= 1'b0;
            link.sdo_oe   <= 1'b0;
        end else if (cs_hi) begin
            conv_active_r <= 1'b0; // [RL22]
            conv_meas_r   <= 1'b0;
            link.busy     <= 1'b0;
            link.sdo      <= 1'b0;
            link.busy_oe  <= 1'b0;
            link.sdo_oe   <= 1'b0;
        end else begin
            link.busy_oe <= 1'b1;
            link.sdo_oe  <= 1'b1;
            if (cmd_done) begin
                conv_active_r <= 1'b1;
                conv_meas_r   <= 1'b1;
                ocnt_r        <= 5'h00;
                conv_mode_r   <= shift_nxt[`TSA_MODE_BIT]; // [RL3]
                conv_touch_r  <= acq_touch_r;
                conv_diff_r   <= ~shift_nxt[`TSA_REFSEL_BIT]; // [RL5]
                conv_pd0_r    <= shift_nxt[`TSA_CONVPWR_BIT];
                conv_pd1_r    <= shift_nxt[`TSA_REFPWR_BIT];
            end else if (sck_fall && conv_active_r) begin
                ocnt_r <= ocnt_nxt;
                if (ocnt_nxt == 5'd1) begin
                    link.busy    <= 1'b1;
                    reference_on <= conv_pd1_r; // [RL11]
                    data_r       <= conv_mode_r ? {conv_data[11:4], 4'h0} : conv_data;
                end else begin
                    link.busy <= 1'b0;
                    link.sdo  <= data_r[11]; // [RL21]
                    data_r    <= {data_r[10:0], 1'b0};
                end
                if (ocnt_nxt == (nbits + 5'd1)) begin
                    conv_meas_r <= 1'b0;
                end
                if (ocnt_nxt == (nbits + 5'd2)) begin
                    conv_active_r <= 1'b0;
                end
            end
        end
    end

    // converter power and pen detect enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_on <= 1'b0;
            pen_en_r     <= 1'b1;
        end else if (cs_hi) begin
            converter_on <= 1'b0; // [RL22]
            pen_en_r     <= ~converter_power_bit;
        end else begin
            if (acq_start) begin
                converter_on <= 1'b1; // [RL7]
            end else if (eoc_ev) begin
                converter_on <= conv_pd0_r; // [RL8] [RL9] [RL10]
            end
            if (cmd_done && shift_nxt[`TSA_CONVPWR_BIT]) begin
                pen_en_r <= 1'b0; // [RL17]
            end else if (eoc_ev && !conv_pd0_r) begin
                pen_en_r <= 1'b1; // [RL18]
            end
        end
    end

    assign measuring  = acquire | conv_meas_r;
    assign meas_touch = acquire ? acq_touch_r : conv_touch_r;

    // panel switches and alert pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.touch_alert_n <= 1'b1;
            xplus_pullup_on    <= 1'b0;
            y_ground_on        <= 1'b0;
            touch_drive_on     <= 1'b0;
        end else begin
            if (measuring) begin
                link.touch_alert_n <= ~meas_touch; // [RL15] [RL16]
            end else begin
                link.touch_alert_n <= pen_en_r ? touch_s : 1'b1; // [RL14] [RL8] [RL10]
            end
            xplus_pullup_on <= pen_en_r & ~(measuring & meas_touch); // [RL15]
            y_ground_on     <= pen_en_r & ~measuring & ~converter_on; // [RL7] [RL14]
            touch_drive_on  <= (acquire & acq_touch_r) |
                               (conv_meas_r & conv_touch_r & conv_diff_r); // [RL2] [RL5]
        end
    end

endmodule : tsa_dev

// ==== tsa_host.sv ====
`timescale 1ns/1ps
`include "tsa_defines.svh"

module tsa_host
    import tsa_pkg::*;
(
    input  logic        pclk,
    input  logic        presetn,
    input  logic [11:0] paddr,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    tsa_link_if.host    link
);

    localparam logic [2:0] SYNC_RST = `TSA_HST_SYNC_RST;
    localparam logic [4:0] HALF_M1  = 5'(`TSA_SCK_HALF_CYC - 1);

    logic [2:0]  pin_raw;
    logic [2:0]  sync1_r;
    logic [2:0]  sync2_r;
    logic [2:0]  sync3_r;
    logic [2:0]  pin_r;
    logic [2:0]  agree;
    logic        acc;
    logic        fin;
    logic        wr_ctrl;
    logic        wr_cmd;
    logic        wr_stat;
    logic [1:0]  ctrl_r;
    logic [7:0]  cmd_r;
    logic [7:0]  cmd_clean;
    logic [15:0] rx_r;
    logic [15:0] result_r;
    logic        done_r;
    logic        alert_flag;
    tsa_host_e   st;
    logic [4:0]  div_r;
    logic [4:0]  clks_r;
    logic [7:0]  tx_r;
    logic        half_end;
    logic        frame_end;
    logic [31:0] rd_mux;

    function automatic logic reg_hit(input logic [11:0] a);
        return (a == `TSA_REG_CTRL) || (a == `TSA_REG_CMD) ||
               (a == `TSA_REG_STATUS) || (a == `TSA_REG_RESULT);
    endfunction : reg_hit

    assign pin_raw = {link.touch_alert_n, link.busy, link.sdo};
    assign agree   = ~(sync2_r ^ sync3_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            sync3_r <= SYNC_RST;
            pin_r   <= SYNC_RST;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_r   <= (agree & sync3_r) | (~agree & pin_r);
        end
    end

    // writes land on the edge that completes the transfer
    assign acc     = psel & penable & ~pready;
    assign fin     = psel & penable & pready;
    assign wr_ctrl = fin & pwrite & (paddr == `TSA_REG_CTRL);
    assign wr_stat = fin & pwrite & (paddr == `TSA_REG_STATUS);
    assign wr_cmd  = fin & pwrite & (paddr == `TSA_REG_CMD) & (st == H_IDLE);

    // start bit forced; ratiometric only allowed on touch channels
    always_comb begin
        cmd_clean = pwdata[7:0];
        cmd_clean[`TSA_START_BIT] = 1'b1; // [RL1]
        if (!tsa_is_touch(pwdata[`TSA_CH_HI:`TSA_CH_LO])) begin
            cmd_clean[`TSA_REFSEL_BIT] = 1'b1; // [RL6]
        end
    end

    assign alert_flag = ~pin_r[2] & ctrl_r[`TSA_CTRL_ALERTEN] & (st == H_IDLE); // [RL19]

    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr)
            `TSA_REG_CTRL:   rd_mux = {30'h0, ctrl_r};
            `TSA_REG_CMD:    rd_mux = {24'h0, cmd_r};
            `TSA_REG_STATUS: rd_mux = {28'h0, pin_r[1], alert_flag, done_r, st != H_IDLE};
            `TSA_REG_RESULT: rd_mux = {16'h0, result_r};
            default:         rd_mux = 32'h0;
        endcase
    end

    // apb slave: one wait state, error on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~reg_hit(paddr);
            if (acc && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `TSA_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata[1:0];
        end
    end

    // done: set by frame end wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r   <= 1'b0;
            result_r <= 16'h0;
        end else if (frame_end) begin
            done_r   <= 1'b1;
            result_r <= rx_r;
        end else if (wr_stat && pwdata[`TSA_STAT_DONE]) begin
            done_r <= 1'b0;
        end
    end

    assign half_end  = (div_r == HALF_M1);
    assign frame_end = (st == H_HIGH) & half_end & (clks_r == `TSA_FRAME_CLKS);

    // serial master: one 24-clock frame per command write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st                <= H_IDLE;
            div_r             <= 5'h0;
            clks_r            <= 5'h0;
            tx_r              <= 8'h0;
            rx_r              <= 16'h0;
            cmd_r             <= 8'h0;
            link.cs_n         <= 1'b1;
            link.serial_clock <= 1'b0;
            link.sdi          <= 1'b0;
        end else begin
            unique case (st)
                H_IDLE: begin
                    if (wr_cmd) begin
                        cmd_r     <= cmd_clean; // [RL12]
                        link.cs_n <= 1'b0; // [RL13]
                        link.sdi  <= cmd_clean[7];
                        tx_r      <= {cmd_clean[6:0], 1'b0};
                        div_r     <= 5'h0;
                        clks_r    <= 5'h0;
                        st        <= H_LOW;
                    end else if (!ctrl_r[`TSA_CTRL_CSHOLD]) begin
                        link.cs_n <= 1'b1;
                    end
                end
                H_LOW: begin
                    if (half_end) begin
                        div_r             <= 5'h0;
                        link.serial_clock <= 1'b1;
                        clks_r            <= clks_r + 5'h1;
                        if (clks_r >= `TSA_RX_FROM) begin
                            rx_r <= {rx_r[14:0], pin_r[0]}; // [RL21]
                        end
                        st <= H_HIGH;
                    end else begin
                        div_r <= div_r + 5'h1;
                    end
                end
                H_HIGH: begin
                    if (half_end) begin
                        div_r             <= 5'h0;
                        link.serial_clock <= 1'b0;
                        if (clks_r == `TSA_FRAME_CLKS) begin
                            link.cs_n <= ~ctrl_r[`TSA_CTRL_CSHOLD]; // [RL20]
                            link.sdi  <= 1'b0;
                            st        <= H_IDLE;
                        end else begin
                            link.sdi <= tx_r[7];
                            tx_r     <= {tx_r[6:0], 1'b0};
                            st       <= H_LOW;
                        end
                    end else begin
                        div_r <= div_r + 5'h1;
                    end
                end
                default: st <= H_IDLE;
            endcase
        end
    end

endmodule : tsa_host

// ==== tsa_link_props.sv ====
`timescale 1ns/1ps

module tsa_link_props (
    input logic pclk,
    input logic presetn,
    input logic serial_clock,
    input logic cs_n,
    input logic sdi,
    input logic sdo,
    input logic sdo_oe,
    input logic busy,
    input logic busy_oe,
    input logic touch_alert_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_SDO_RELEASE: assert property ($rose(cs_n) |-> ##[1:8] !sdo_oe)
        else $error("result line still driven after deselect");
    AST_SDO_DRIVE: assert property ($fell(cs_n) |-> ##[1:8] sdo_oe)
        else $error("result line not driven after select");
    AST_BUSY_RELEASE: assert property ($rose(cs_n) |-> ##[1:8] (!busy && !busy_oe))
        else $error("busy still driven after deselect");
    AST_SDO_ON_FALL: assert property ($changed(sdo) |-> !serial_clock)
        else $error("result bit changed while serial clock high");
    AST_BUSY_ON_FALL: assert property ($changed(busy) |-> !serial_clock)
        else $error("busy changed while serial clock high");
    AST_BUSY_WIDTH: assert property ($rose(busy) |-> busy [*8] ##[14:20] !busy)
        else $error("busy not one serial period wide");
    AST_SDO_QUIET_BUSY: assert property (busy |-> !sdo)
        else $error("result bit high before first result clock");
    AST_BUSY_SELECTED: assert property ($rose(busy) |-> !cs_n)
        else $error("busy rose while deselected");

    cover property ($rose(busy));
    cover property ($fell(touch_alert_n));
    cover property ($fell(sdo));
endmodule : tsa_link_props

// ==== touch_adc_command_decoder_test.sv ====
`timescale 1ns/1ps

`define CHK(x, y) begin samples_checked++; if ((x) !== (y)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, x, y); end end

module touch_adc_command_decoder_test
    import tsa_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, touch_sense_n;
    logic [11:0] paddr, conv_data;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  channel_code;
    logic        reference_select, resolution_8bit, reference_power_bit, converter_power_bit;
    logic        acquire, touch_drive_on, reference_on, converter_on, y_ground_on, xplus_pullup_on;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          rises = 0;
    logic [7:0]  cmds [8] = '{8'h93, 8'hb9, 8'hc2, 8'hd4, 8'h08, 8'ha0, 8'he6, 8'hfd};

    tsa_link_if link();
    tsa_host i_tsa_host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .link(link));
    tsa_dev i_tsa_dev (.pclk, .presetn, .link(link), .conv_data, .touch_sense_n, .channel_code,
        .reference_select, .resolution_8bit, .reference_power_bit, .converter_power_bit, .acquire,
        .touch_drive_on, .reference_on, .converter_on, .y_ground_on, .xplus_pullup_on);
    tsa_link_props i_tsa_link_props (.pclk, .presetn, .serial_clock(link.serial_clock),
        .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe), .busy(link.busy),
        .busy_oe(link.busy_oe), .touch_alert_n(link.touch_alert_n));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge link.serial_clock) rises++;

    task automatic tally_and_finish;
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // one full frame, then result, fields, power and pen alert
    task automatic conv(input logic [7:0] c, input logic [11:0] v);
        logic t;
        logic [7:0] e;
        int n, r0;
        t = (c[6:4] == 3'd1) || (c[6:4] == 3'd3) || (c[6:4] == 3'd4) || (c[6:4] == 3'd5);
        e = {1'b1, c[6:3], c[2] | ~t, c[1:0]};
        conv_data <= v;
        apb(1'b1, 12'h000, {30'h0, 1'b1, c[0]});
        r0 = rises;
        apb(1'b1, 12'h004, {24'h0, c});
        n = 0;
        while (link.busy !== 1'b1 && n < 2000) begin @(posedge pclk); n++; end
        `CHK(link.busy, 1'b1)
        repeat (4) @(posedge pclk);
        `CHK(link.touch_alert_n, ~t)
        `CHK({touch_drive_on, acquire}, {t & ~e[2], 1'b0})
        n = 0;
        do begin apb(1'b0, 12'h008, 32'h0); n++; end while (rd[1] !== 1'b1 && n < 300);
        `CHK(rd[1], 1'b1)
        `CHK(rises - r0, 24)
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rd[7:0], e)
        apb(1'b0, 12'h00c, 32'h0);
        if (c[3]) `CHK(rd[14:7], v[11:4])
        else `CHK(rd[14:3], v)
        `CHK({channel_code, resolution_8bit, reference_select, reference_power_bit,
              converter_power_bit}, e[6:0])
        `CHK(reference_on, c[1])
        `CHK(converter_on, c[0])
        `CHK(y_ground_on, ~c[0])
        `CHK(xplus_pullup_on, ~c[0])
        touch_sense_n <= 1'b0;
        repeat (12) @(posedge pclk);
        `CHK(link.touch_alert_n, c[0])
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rd[2], ~c[0])
        touch_sense_n <= 1'b1;
        repeat (12) @(posedge pclk);
    endtask : conv

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; conv_data = 12'h000; touch_sense_n = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rd, 32'h2)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        foreach (cmds[i]) conv(cmds[i], {~cmds[i][3:0], cmds[i]});
        tally_and_finish();
    end

    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end
endmodule : touch_adc_command_decoder_test
